// >>> ccmr_regs.vh
`ifndef CCMR_REGS_VH
`define CCMR_REGS_VH

// ----------------------------------------------------------------------
// Register addresses on the special function register bus.
// ----------------------------------------------------------------------
`define CCMR_MODE0_ADDR      8'hda
`define CCMR_MODE1_ADDR      8'hdb
`define CCMR_MODE2_ADDR      8'hdc
`define CCMR_MODE3_ADDR      8'hdd
`define CCMR_MODE4_ADDR      8'hde
`define CCMR_MODE5_ADDR      8'hce
`define CCMR_LOW0_ADDR       8'hfb
`define CCMR_LOW1_ADDR       8'he9
`define CCMR_LOW2_ADDR       8'heb
`define CCMR_LOW3_ADDR       8'hed
`define CCMR_LOW4_ADDR       8'hfd
`define CCMR_LOW5_ADDR       8'hd2
`define CCMR_HIGH0_ADDR      8'hfc
`define CCMR_HIGH1_ADDR      8'hea
`define CCMR_HIGH2_ADDR      8'hec
`define CCMR_HIGH3_ADDR      8'hee
`define CCMR_HIGH4_ADDR      8'hfe
`define CCMR_HIGH5_ADDR      8'hd3

// ----------------------------------------------------------------------
// Field positions inside each mode register.
// ----------------------------------------------------------------------
`define CCMR_WIDE_MOD_BIT    7
`define CCMR_COMPARE_EN_BIT  6
`define CCMR_RISE_CAP_BIT    5
`define CCMR_FALL_CAP_BIT    4
`define CCMR_MATCH_FLAG_BIT  3
`define CCMR_TOGGLE_EN_BIT   2
`define CCMR_WIDTH_MOD_BIT   1
`define CCMR_FLAG_IRQ_BIT    0

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define CCMR_MODE_RESET      8'h00
`define CCMR_LOW_RESET       8'h00
`define CCMR_HIGH_RESET      8'h00

`endif

// >>> ccmr_reset_sync.v
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// Reset release synchroniser.
// ----------------------------------------------------------------------
module ccmr_reset_sync (
    // Clock and raw reset.
    input  wire ref_clk,
    input  wire resetn,
    // Reset released in step with the clock.
    output wire sync_resetn
);

    reg stage_a;
    reg stage_b;

    // Assert at once, release two edges later to avoid metastable release.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stage_a <= 1'b0;
            stage_b <= 1'b0;
        end else begin
            stage_a <= 1'b1;
            stage_b <= stage_a;
        end
    end

    assign sync_resetn = stage_b;

endmodule // ccmr_reset_sync

`default_nettype wire

// >>> ccmr_channel.v
`timescale 1ns/1ns
`default_nettype none
`include "ccmr_regs.vh"

// ----------------------------------------------------------------------
// One capture/compare module: match, capture edges and output pin.
// ----------------------------------------------------------------------
module ccmr_channel (
    // Clock and reset.
    input  wire        ref_clk,
    input  wire        rst_n,
    // Mode and value registers.
    input  wire [7:0]  mode,
    input  wire [15:0] value,
    // Counter array time base.
    input  wire [15:0] counter,
    input  wire        counter_step,
    // Module pin.
    input  wire        pin_in,
    output reg         pin_out,
    // Events towards the register file.
    output wire        match,
    output wire        capture,
    output wire        freq_add,
    output wire        reload
);

    reg  pin_prev;
    wire comp_en = mode[`CCMR_COMPARE_EN_BIT];
    wire tog_en  = mode[`CCMR_TOGGLE_EN_BIT];
    wire pwm_en  = mode[`CCMR_WIDTH_MOD_BIT];
    wire wide    = mode[`CCMR_WIDE_MOD_BIT];
    wire freq    = tog_en & pwm_en;
    wire eq_full = (counter == value);
    wire eq_low  = (counter[7:0] == value[7:0]);

    // Comparison only runs while the comparator is enabled.
    assign match    = comp_en & counter_step &
                      ((freq | (pwm_en & ~wide)) ? eq_low : eq_full);
    // Frequency output advances its next toggle point by the high byte.
    assign freq_add = match & freq;
    // 8-bit modulation reloads the duty byte when the low count wraps.
    assign reload   = comp_en & pwm_en & ~tog_en & ~wide & counter_step &
                      (counter[7:0] == 8'h00);
    // Capture on chosen pin edges; sample taken from the previous cycle.
    assign capture  = (mode[`CCMR_RISE_CAP_BIT] & pin_in & ~pin_prev) |
                      (mode[`CCMR_FALL_CAP_BIT] & ~pin_in & pin_prev);

    // Output pin: toggle, frequency output or modulated level.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev <= 1'b0;
            pin_out  <= 1'b0;
        end else begin
            pin_prev <= pin_in;
            if (tog_en && match) begin
                pin_out <= ~pin_out;
            end else if (pwm_en && !tog_en && comp_en) begin
                if (wide) begin
                    pin_out <= (counter >= value);
                end else begin
                    pin_out <= (counter[7:0] >= value[7:0]);
                end
            end
        end
    end

endmodule // ccmr_channel

`default_nettype wire

// >>> ccmr_top.v
`timescale 1ns/1ns
`default_nettype none
`include "ccmr_regs.vh"

// ----------------------------------------------------------------------
// Capture/compare register block of the counter array.
// ----------------------------------------------------------------------

module ccmr_top #(
    parameter NUM_MODULES = 6
) (
    // Clock and reset.
    input  wire                   ref_clk,
    input  wire                   resetn,
    // Special function register bus.
    input  wire [7:0]             sfr_addr,
    input  wire [7:0]             sfr_wdata,
    input  wire                   sfr_wr,
    input  wire                   sfr_rd,
    output reg  [7:0]             sfr_rdata,
    // Counter array time base.
    input  wire [15:0]            counter_value,
    input  wire                   counter_step,
    // Flag clear from the counter array control register.
    input  wire [NUM_MODULES-1:0] flag_clear,
    // Module pins.
    input  wire [NUM_MODULES-1:0] module_input_pin,
    output wire [NUM_MODULES-1:0] module_output_pin,
    // Events.
    output reg  [NUM_MODULES-1:0] module_event_flag,
    output reg                    irq_request
);

    // ------------------------------------------------------------------
    // Address tables, module 0 in the lowest byte.
    // ------------------------------------------------------------------
    localparam [47:0] MODE_ADDRS = {`CCMR_MODE5_ADDR, `CCMR_MODE4_ADDR,
                                    `CCMR_MODE3_ADDR, `CCMR_MODE2_ADDR,
                                    `CCMR_MODE1_ADDR, `CCMR_MODE0_ADDR};
    localparam [47:0] LOW_ADDRS  = {`CCMR_LOW5_ADDR, `CCMR_LOW4_ADDR,
                                    `CCMR_LOW3_ADDR, `CCMR_LOW2_ADDR,
                                    `CCMR_LOW1_ADDR, `CCMR_LOW0_ADDR};
    localparam [47:0] HIGH_ADDRS = {`CCMR_HIGH5_ADDR, `CCMR_HIGH4_ADDR,
                                    `CCMR_HIGH3_ADDR, `CCMR_HIGH2_ADDR,
                                    `CCMR_HIGH1_ADDR, `CCMR_HIGH0_ADDR};

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    wire                   rst_n;
    reg  [7:0]             mode      [0:NUM_MODULES-1];
    reg  [7:0]             value_low [0:NUM_MODULES-1];
    reg  [7:0]             value_high[0:NUM_MODULES-1];
    wire [NUM_MODULES-1:0] match;
    wire [NUM_MODULES-1:0] capture;
    wire [NUM_MODULES-1:0] freq_add;
    wire [NUM_MODULES-1:0] reload;
    reg  [NUM_MODULES-1:0] hit_mode;
    reg  [NUM_MODULES-1:0] hit_low;
    reg  [NUM_MODULES-1:0] hit_high;
    reg  [NUM_MODULES-1:0] flag_set;
    reg  [NUM_MODULES-1:0] irq_enable;
    reg  [NUM_MODULES-1:0] next_flag;
    reg  [7:0]             next_rdata;
    integer                k_dec;
    integer                k_mode;
    integer                k_val;
    integer                k_flag;
    integer                k_rd;

    // ------------------------------------------------------------------
    // Reset release.
    // ------------------------------------------------------------------
    ccmr_reset_sync u_reset_sync (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .sync_resetn (rst_n)
    );

    // ------------------------------------------------------------------
    // Address decode: one hit vector per register kind.
    // ------------------------------------------------------------------
    // Every module's three registers sit at their own address.
    always @* begin
        for (k_dec = 0; k_dec < NUM_MODULES; k_dec = k_dec + 1) begin
            hit_mode[k_dec] = (sfr_addr == MODE_ADDRS[k_dec*8 +: 8]);
            hit_low[k_dec]  = (sfr_addr == LOW_ADDRS[k_dec*8 +: 8]);
            hit_high[k_dec] = (sfr_addr == HIGH_ADDRS[k_dec*8 +: 8]);
        end
    end

    // ------------------------------------------------------------------
    // Per-module logic.
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_MODULES; g = g + 1) begin : g_mod
            ccmr_channel u_channel (
                .ref_clk      (ref_clk),
                .rst_n        (rst_n),
                .mode         (mode[g]),
                .value        ({value_high[g], value_low[g]}),
                .counter      (counter_value),
                .counter_step (counter_step),
                .pin_in       (module_input_pin[g]),
                .pin_out      (module_output_pin[g]),
                .match        (match[g]),
                .capture      (capture[g]),
                .freq_add     (freq_add[g]),
                .reload       (reload[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Mode registers.
    // ------------------------------------------------------------------
    // Software owns the mode bits; nothing in hardware changes them.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (k_mode = 0; k_mode < NUM_MODULES; k_mode = k_mode + 1) begin
                mode[k_mode] <= `CCMR_MODE_RESET;
            end
        end else begin
            for (k_mode = 0; k_mode < NUM_MODULES; k_mode = k_mode + 1) begin
                if (sfr_wr && hit_mode[k_mode]) begin
                    mode[k_mode] <= sfr_wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Value registers.
    // ------------------------------------------------------------------
    // A capture wins over a software write in the same cycle, so a pin
    // edge is never lost; frequency output and 8-bit reload move the low
    // byte only, and a software write to it takes precedence there.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (k_val = 0; k_val < NUM_MODULES; k_val = k_val + 1) begin
                value_low[k_val]  <= `CCMR_LOW_RESET;
                value_high[k_val] <= `CCMR_HIGH_RESET;
            end
        end else begin
            for (k_val = 0; k_val < NUM_MODULES; k_val = k_val + 1) begin
                if (capture[k_val]) begin
                    value_low[k_val]  <= counter_value[7:0];
                    value_high[k_val] <= counter_value[15:8];
                end else begin
                    if (sfr_wr && hit_low[k_val]) begin
                        value_low[k_val] <= sfr_wdata;
                    end else if (freq_add[k_val]) begin
                        value_low[k_val] <= value_low[k_val] +
                                            value_high[k_val];
                    end else if (reload[k_val]) begin
                        value_low[k_val] <= value_high[k_val];
                    end
                    if (sfr_wr && hit_high[k_val]) begin
                        value_high[k_val] <= sfr_wdata;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Event flags and interrupt request.
    // ------------------------------------------------------------------
    // A new event in the clearing cycle keeps the flag set.
    always @* begin
        for (k_flag = 0; k_flag < NUM_MODULES; k_flag = k_flag + 1) begin
            flag_set[k_flag]   = capture[k_flag] |
                                 (match[k_flag] &
                                  mode[k_flag][`CCMR_MATCH_FLAG_BIT]);
            irq_enable[k_flag] = mode[k_flag][`CCMR_FLAG_IRQ_BIT];
        end
        next_flag = (module_event_flag & ~flag_clear) | flag_set;
    end

    // The request is registered so the output comes from a flip-flop.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            module_event_flag <= {NUM_MODULES{1'b0}};
            irq_request       <= 1'b0;
        end else begin
            module_event_flag <= next_flag;
            irq_request       <= |(next_flag & irq_enable);
        end
    end

    // ------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------
    // Unmapped addresses read as zero.
    always @* begin
        next_rdata = 8'h00;
        for (k_rd = 0; k_rd < NUM_MODULES; k_rd = k_rd + 1) begin
            if (hit_mode[k_rd]) begin
                next_rdata = mode[k_rd];
            end
            if (hit_low[k_rd]) begin
                next_rdata = value_low[k_rd];
            end
            if (hit_high[k_rd]) begin
                next_rdata = value_high[k_rd];
            end
        end
    end

    // Read data is held until the next read strobe.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end

endmodule // ccmr_top

`default_nettype wire

// >>> ccmr_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccmr_regs.vh"
// ------
// Port checker for the capture/compare block.
// ------
module ccmr_monitor #(
    parameter NUM_MODULES = 6
) (
    // Clock and reset.
    input wire logic                   ref_clk,
    input wire logic                   resetn,
    // Register bus.
    input wire logic [7:0]             sfr_addr,
    input wire logic [7:0]             sfr_wdata,
    input wire logic                   sfr_wr,
    input wire logic                   sfr_rd,
    input wire logic [7:0]             sfr_rdata,
    // Time base and pins.
    input wire logic [15:0]            counter_value,
    input wire logic                   counter_step,
    input wire logic [NUM_MODULES-1:0] flag_clear,
    input wire logic [NUM_MODULES-1:0] module_input_pin,
    input wire logic [NUM_MODULES-1:0] module_output_pin,
    input wire logic [NUM_MODULES-1:0] module_event_flag,
    input wire logic                   irq_request
);
    logic [7:0] mode0;
    logic [7:0] low0;
    logic [7:0] high0;
    wire        hit0;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Shadow of module 0 as software wrote it; hardware never edits mode.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode0 <= 8'h00;
            low0 <= 8'h00;
            high0 <= 8'h00;
        end else if (sfr_wr && sfr_addr == `CCMR_MODE0_ADDR) begin
            mode0 <= sfr_wdata;
        end else if (sfr_wr && sfr_addr == `CCMR_LOW0_ADDR) begin
            low0 <= sfr_wdata;
        end else if (sfr_wr && sfr_addr == `CCMR_HIGH0_ADDR) begin
            high0 <= sfr_wdata;
        end
    end

    // A plain 16-bit match; capture and modulation modes excluded.
    assign hit0 = counter_step && mode0[6] && mode0[5:4] == 2'h0 &&
                  !mode0[1] && !sfr_wr && counter_value == {high0, low0};

    chk_match_flag: assert property (hit0 && mode0[3] |=>
        module_event_flag[0]) else $error("match flag not set");
    chk_toggle_pin: assert property (hit0 && mode0[2] |=>
        module_output_pin[0] != $past(module_output_pin[0]))
        else $error("pin did not toggle on match");
    chk_no_compare: assert property (!mode0[6] |=>
        $stable(module_output_pin[0])) else $error("pin moved");
    chk_mode_readback: assert property (sfr_rd && !sfr_wr &&
        sfr_addr == `CCMR_MODE0_ADDR |=> sfr_rdata == mode0)
        else $error("mode readback wrong");
    chk_rd_unmapped: assert property (sfr_rd && sfr_addr < 8'hce
        |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!sfr_rd |=>
        $stable(sfr_rdata)) else $error("read data moved");
    chk_irq_cause: assert property ($rose(irq_request) |->
        module_event_flag != '0) else $error("request without flag");
    chk_flag_sticky: assert property ((~module_event_flag &
        $past(module_event_flag) & ~$past(flag_clear)) == '0)
        else $error("flag dropped without clear");

    cover property (hit0 && mode0[2]);
    cover property ($rose(irq_request));
    cover property (sfr_rd && sfr_addr < 8'hce);
endmodule // ccmr_monitor

bind ccmr_top ccmr_monitor #(.NUM_MODULES(NUM_MODULES)) u_mon (
    .ref_clk, .resetn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sfr_rdata, .counter_value, .counter_step, .flag_clear,
    .module_input_pin, .module_output_pin, .module_event_flag,
    .irq_request);
`default_nettype wire

// >>> ccmr_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------
// Far-side pins feeding the capture inputs.
// ------
module ccmr_pin_model (
    // Clock and requested levels.
    input wire logic       ref_clk,
    input wire logic [5:0] want_pin,
    // Pin levels seen by the block.
    output var logic [5:0] module_input_pin
);
    // Pins move just after an edge, since the block has no synchroniser.
    initial module_input_pin = 6'h00;
    always @(posedge ref_clk) begin
        module_input_pin <= #1 want_pin;
    end
endmodule // ccmr_pin_model
`default_nettype wire

// >>> capture_compare_module_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccmr_regs.vh"
// ------
// Self-checking bench.
// ------
module capture_compare_module_regs_tb;
    logic        ref_clk, resetn, sfr_wr, sfr_rd, counter_step, irq_request;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, d;
    logic [15:0] counter_value;
    logic [5:0]  flag_clear, want_pin, module_input_pin;
    logic [5:0]  module_output_pin, module_event_flag;
    logic [7:0]  regs [18];
    logic [7:0]  shadow [18];
    logic        p;
    integer      seed = 71014;
    integer      fails = 0;
    integer      n_compared = 0;
    integer      i;

    ccmr_top #(.NUM_MODULES(6)) dut (.ref_clk, .resetn, .sfr_addr,
        .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .counter_value,
        .counter_step, .flag_clear, .module_input_pin,
        .module_output_pin, .module_event_flag, .irq_request);
    ccmr_pin_model pins (.ref_clk, .want_pin, .module_input_pin);

    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Every task starts and ends 1 ns after a rising edge.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        tick(1);
        d = sfr_rdata;
    endtask
    task automatic step(input logic [15:0] v);
        counter_value = v;
        counter_step = 1'b1;
        tick(1);
        counter_step = 1'b0;
        tick(1);
    endtask
    task automatic clr();
        flag_clear = 6'h3f;
        tick(1);
        flag_clear = 6'h00;
        tick(1);
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task stop_test;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Expected pin of the modulator: high once the count reaches the value.
    function automatic logic pwm_exp(logic [15:0] c, logic [15:0] v);
        return c >= v;
    endfunction

    // A hang is cut short well past the expected run length.
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        stop_test;
    end

    // Main sequence.
    initial begin
        regs = '{`CCMR_MODE0_ADDR, `CCMR_MODE1_ADDR, `CCMR_MODE2_ADDR,
            `CCMR_MODE3_ADDR, `CCMR_MODE4_ADDR, `CCMR_MODE5_ADDR,
            `CCMR_LOW0_ADDR, `CCMR_LOW1_ADDR, `CCMR_LOW2_ADDR,
            `CCMR_LOW3_ADDR, `CCMR_LOW4_ADDR, `CCMR_LOW5_ADDR,
            `CCMR_HIGH0_ADDR, `CCMR_HIGH1_ADDR, `CCMR_HIGH2_ADDR,
            `CCMR_HIGH3_ADDR, `CCMR_HIGH4_ADDR, `CCMR_HIGH5_ADDR};
        {resetn, sfr_wr, sfr_rd, counter_step} = 4'h0;
        {sfr_addr, sfr_wdata, counter_value} = 32'h0;
        {flag_clear, want_pin} = 12'h0;
        tick(16);
        resetn = 1'b1;
        tick(3);
        for (i = 0; i < 18; i++) begin
            rd(regs[i]);
            chk("reset value", 16'h0, d);
            shadow[i] = 8'($random(seed));
            wr(regs[i], shadow[i]);
        end
        for (i = 0; i < 18; i++) begin
            rd(regs[i]);
            chk("readback", shadow[i], d);
        end
        rd(8'h10);
        chk("unmapped read", 16'h0, d);
        // Toggle with flag and request, then comparator off.
        wr(`CCMR_MODE0_ADDR, 8'h4d);
        wr(`CCMR_LOW0_ADDR, 8'h10);
        wr(`CCMR_HIGH0_ADDR, 8'h00);
        clr();
        p = module_output_pin[0];
        step(16'h0010);
        chk("toggle pin", !p, module_output_pin[0]);
        chk("match flag", 1'b1, module_event_flag[0]);
        chk("irq request", 1'b1, irq_request);
        clr();
        chk("flag cleared", 1'b0, module_event_flag[0]);
        wr(`CCMR_MODE0_ADDR, 8'h0c);
        p = module_output_pin[0];
        step(16'h0010);
        chk("disabled pin", p, module_output_pin[0]);
        chk("disabled flag", 1'b0, module_event_flag[0]);
        // Frequency output: toggle and low byte advanced by the high byte.
        wr(`CCMR_MODE0_ADDR, 8'h46);
        wr(`CCMR_HIGH0_ADDR, 8'h05);
        p = module_output_pin[0];
        step(16'h0010);
        chk("freq pin", !p, module_output_pin[0]);
        rd(`CCMR_LOW0_ADDR);
        chk("freq low", 16'h15, d);
        // Another module's pin toggles from its own registers.
        wr(`CCMR_MODE5_ADDR, 8'h44);
        wr(`CCMR_LOW5_ADDR, 8'h20);
        wr(`CCMR_HIGH5_ADDR, 8'h00);
        p = module_output_pin[5];
        step(16'h0020);
        chk("toggle pin 5", !p, module_output_pin[5]);
        // Sixteen-bit then eight-bit modulation at random counts.
        wr(`CCMR_MODE0_ADDR, 8'hc2);
        wr(`CCMR_LOW0_ADDR, 8'h00);
        wr(`CCMR_HIGH0_ADDR, 8'h80);
        repeat (6) begin
            counter_value = 16'($random(seed));
            tick(2);
            chk("pwm16", pwm_exp(counter_value, 16'h8000),
                module_output_pin[0]);
        end
        wr(`CCMR_MODE0_ADDR, 8'h42);
        wr(`CCMR_LOW0_ADDR, 8'h80);
        repeat (6) begin
            counter_value = 16'($random(seed));
            tick(2);
            chk("pwm8", pwm_exp(counter_value[7:0], 16'h80),
                module_output_pin[0]);
        end
        // Rising edge capture with request.
        wr(`CCMR_MODE0_ADDR, 8'h21);
        clr();
        counter_value = 16'h1234;
        want_pin = 6'h01;
        tick(4);
        chk("capture flag", 1'b1, module_event_flag[0]);
        chk("capture irq", 1'b1, irq_request);
        rd(`CCMR_LOW0_ADDR);
        chk("capture low", 16'h34, d);
        rd(`CCMR_HIGH0_ADDR);
        chk("capture high", 16'h12, d);
        stop_test;
    end
endmodule // capture_compare_module_regs_tb
`default_nettype wire
